// file: dv/spi_partner.sv
// behavioural spi partner: slave to a port master, master to a port slave
`timescale 1ns/1ps
module spi_partner (
  input  wire logic       port_sck,
  input  wire logic       port_sck_oe,
  input  wire logic       port_data,
  input  wire logic       clock_idle_polarity,
  input  wire logic       cke,
  output logic            sck,
  output logic            data,
  output logic            select_n,
  output logic [7:0]      got
);
  logic [7:0] tx;
  int         edges;

  initial begin
    sck = 1'b0;
    data = 1'b0;
    select_n = 1'b1;
    got = 8'h00;
    tx = 8'h00;
    edges = 0;
  end

  task automatic load(input logic [7:0] b);
    tx = b;
    data = b[7];
    edges = 0;
  endtask : load

  // outside a frame the driven clock follows the idle level, so no stray edge opens a frame
  always @(clock_idle_polarity) begin
    if (select_n) begin
      sck = clock_idle_polarity;
    end
  end

  // slave side: sample on the port's sampling edge, change on the other
  always @(port_sck) begin
    if (port_sck_oe) begin
      edges++;
      if ((port_sck != clock_idle_polarity) == cke) begin
        got = {got[6:0], port_data};
      end else if (edges > 1) begin
        tx = {tx[6:0], ~tx[0]};
        data = tx[7];
      end
    end
  end

  // master side: 800 ns clock only inside a frame, line inverted when released
  task automatic frame(input logic [7:0] b, input int n);
    sck = clock_idle_polarity;
    #437;
    select_n = 1'b0;
    data = b[7];
    #400;
    for (int i = 0; i < n; i++) begin
      sck = ~clock_idle_polarity;
      if (cke) got = {got[6:0], port_data};
      else if (i > 0) data = b[7-i];
      #400;
      sck = clock_idle_polarity;
      if (!cke) got = {got[6:0], port_data};
      else if (i < 7) data = b[6-i];
      #400;
    end
    select_n = 1'b1;
    data = ~data;
  endtask : frame
endmodule : spi_partner

// file: dv/test_sync_serial_port_spi.sv
// self-checking bench for the serial port with a behavioural partner
`timescale 1ns/1ps
module test_sync_serial_port_spi;
  logic       mclk;
  logic       reset_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       tmr_pulse;
  logic       sck_line;
  logic       sck_out;
  logic       sck_oe;
  logic       in_line;
  logic       serial_out;
  logic       serial_out_oe;
  logic       sel_n;
  logic       irq;
  logic       clock_idle_polarity;
  logic       cke;
  logic [7:0] got;
  logic [2:0] tdiv;
  int         err_total;
  int         tests_run;

  sync_serial_port_spi i_sync_serial_port_spi (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_two_match(tmr_pulse), .sck_in(sck_line), .sck_out(sck_out),
    .sck_oe(sck_oe), .serial_in(in_line), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .slave_select_n(sel_n), .irq(irq));

  spi_partner i_spi_partner (
    .port_sck(sck_out), .port_sck_oe(sck_oe), .port_data(serial_out),
    .clock_idle_polarity(clock_idle_polarity), .cke(cke), .sck(sck_line),
    .data(in_line), .select_n(sel_n), .got(got));

  always #50 mclk = ~mclk;

  // timer pulse every fifth cycle
  always @(posedge mclk) begin
    tdiv <= (tdiv == 3'h4) ? 3'h0 : tdiv + 3'h1;
    tmr_pulse <= (tdiv == 3'h4);
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_reg

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic wait_irq();
    int c;
    c = 0;
    while (irq !== 1'b1 && c < 4000) begin
      settle(1);
      c++;
    end
    if (c == 4000) begin
      err_total++;
      $display("Error at %0t: no interrupt", $time);
      wrap_up();
    end
  endtask : wait_irq

  task automatic cfg(input logic [7:0] ctrl, input logic e, input logic [7:0] dirc);
    wr_reg(8'h14, 8'h00);
    wr_reg(8'h87, dirc);
    wr_reg(8'h94, {1'b0, e, 6'h00});
    wr_reg(8'h8C, 8'h08);
    wr_reg(8'h14, ctrl);
    rd_reg(8'h14, ctrl);
    settle(3);
  endtask : cfg

  task automatic t_reset();
    logic [7:0] a [8] = '{8'h0B, 8'h0C, 8'h14, 8'h85, 8'h87, 8'h8C, 8'h94, 8'h20};
    logic [7:0] v [8] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'hFF, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd_reg(a[i], v[i]);
    chk({sck_oe, serial_out_oe, irq}, 3'h0);
    wr_reg(8'h0B, 8'h5A);
    rd_reg(8'h0B, 8'h5A);
    wr_reg(8'h85, 8'hFF);
    rd_reg(8'h85, 8'h3F);
    wr_reg(8'h20, 8'hFF);
    rd_reg(8'h20, 8'h00);
  endtask : t_reset

  task automatic t_master(input logic [3:0] m, input logic k, input logic e,
                          input logic [7:0] tx, input logic [7:0] rx, input int half);
    int   tog;
    int   first;
    int   last;
    logic prev;
    clock_idle_polarity = k;
    cke = e;
    cfg({2'b00, 1'b1, k, m}, e, 8'hD7);
    i_spi_partner.load(rx);
    chk({sck_oe, serial_out_oe}, 2'h3);
    chk(sck_out, k);
    wr_reg(8'h13, tx);
    #1;
    tog = 0;
    first = 0;
    last = 0;
    prev = sck_out;
    // count by edges, not by the interrupt: with leading-edge sampling it beats the last edge
    for (int c = 0; c < 3000 && tog < 16; c++) begin
      settle(1);
      if (sck_out !== prev) begin
        if (tog == 0) first = c;
        last = c;
        tog++;
      end
      prev = sck_out;
    end
    wait_irq();
    chk(tog, 16);
    chk(last - first, 15 * half);
    chk(got, tx);
    chk(sck_out, k);
    rd_reg(8'h94, {1'b0, e, 6'h01});
    rd_reg(8'h13, rx);
    rd_reg(8'h94, {1'b0, e, 6'h00});
    rd_reg(8'h0C, 8'h08);
    wr_reg(8'h8C, 8'h00);
    settle(2);
    chk(irq, 1'b0);
    wr_reg(8'h8C, 8'h08);
    settle(2);
    chk(irq, 1'b1);
    wr_reg(8'h0C, 8'h08);
    settle(2);
    chk(irq, 1'b0);
  endtask : t_master

  task automatic t_collision();
    clock_idle_polarity = 1'b0;
    cke = 1'b1;
    cfg(8'h22, 1'b1, 8'hD7);
    i_spi_partner.load(8'h0F);
    wr_reg(8'h13, 8'hA5);
    wr_reg(8'h13, 8'h3C);
    rd_reg(8'h14, 8'hA2);
    wait_irq();
    chk(got, 8'hA5);
    wr_reg(8'h14, 8'h22);
    rd_reg(8'h14, 8'h22);
    rd_reg(8'h13, 8'h0F);
    wr_reg(8'h0C, 8'h08);
  endtask : t_collision

  task automatic t_slave(input logic [3:0] m, input logic k, input logic e,
                         input logic [7:0] tx, input logic [7:0] rx);
    clock_idle_polarity = k;
    cke = e;
    cfg({2'b00, 1'b1, k, m}, e, 8'hDF);
    chk(sck_oe, 1'b0);
    wr_reg(8'h13, tx);
    if (m == 4'h4) begin
      chk(serial_out_oe, 1'b0);
      i_spi_partner.frame(~rx, 3);
      settle(4);
      chk(serial_out_oe, 1'b0);
    end
    i_spi_partner.frame(rx, 8);
    wait_irq();
    rd_reg(8'h13, rx);
    wr_reg(8'h0C, 8'h08);
    if (m == 4'h5) begin
      chk(got, tx);
      i_spi_partner.frame(~rx, 8);
      wait_irq();
      rd_reg(8'h14, {2'b00, 1'b1, k, m});
      rd_reg(8'h94, {1'b0, e, 6'h01});
      wr_reg(8'h0C, 8'h08);
      // third byte arrives while the buffer is still full
      i_spi_partner.frame(rx, 8);
      wait_irq();
      rd_reg(8'h14, {2'b01, 1'b1, k, m});
      wr_reg(8'h0C, 8'h08);
    end
    rd_reg(8'h13, (m == 4'h5) ? ~rx : rx);
  endtask : t_slave

  task automatic t_wire();
    cfg(8'h26, 1'b0, 8'hFF);
    chk({sck_oe, sck_out}, 2'h2);
    cfg(8'h36, 1'b0, 8'hFF);
    chk(sck_oe, 1'b0);
    wr_reg(8'h14, 8'h00);
    settle(3);
    chk({sck_oe, serial_out_oe}, 2'h0);
  endtask : t_wire

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    tmr_pulse = 1'b0;
    tdiv = 3'h0;
    clock_idle_polarity = 1'b0;
    cke = 1'b1;
    err_total = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_master(4'h0, 1'b0, 1'b1, 8'hA5, 8'hFF, 2);
    t_master(4'h1, 1'b1, 1'b1, 8'h81, 8'h7E, 8);
    t_master(4'h2, 1'b0, 1'b0, 8'h5A, 8'hC3, 32);
    t_master(4'h3, 1'b1, 1'b0, 8'h96, 8'h69, 5);
    t_collision();
    t_slave(4'h4, 1'b0, 1'b1, 8'hB4, 8'h4B);
    t_slave(4'h5, 1'b1, 1'b0, 8'hE1, 8'h1E);
    t_wire();
    wrap_up();
  end
endmodule : test_sync_serial_port_spi

// file: rtl/spi_port_cfg.svh
// register map, field positions, reset values and clock counts of the serial port
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

`define CFG_ADDR_INT_CTRL 8'h0B
`define CFG_ADDR_FLAGS    8'h0C
`define CFG_ADDR_BUFFER   8'h13
`define CFG_ADDR_CONTROL  8'h14
`define CFG_ADDR_DIR_A    8'h85
`define CFG_ADDR_DIR_C    8'h87
`define CFG_ADDR_ENABLES  8'h8C
`define CFG_ADDR_STATUS   8'h94

`define CFG_RST_INT_CTRL  8'h00
`define CFG_RST_CONTROL   8'h00
`define CFG_RST_STATUS    8'h00
`define CFG_RST_DIR_A     6'h3F
`define CFG_RST_DIR_C     8'hFF
`define CFG_RST_BUFFER    8'h00

`define CFG_CTRL_COLL     7
`define CFG_CTRL_OVF      6
`define CFG_CTRL_EN       5
`define CFG_CTRL_POL      4
`define CFG_STAT_PHASE    7
`define CFG_STAT_CKE      6
`define CFG_STAT_BF       0
`define CFG_FLAG_PORT     3
`define CFG_ENA_PORT      3
`define CFG_DIR_C_SCK     3
`define CFG_DIR_C_DIN     4
`define CFG_DIR_C_DOUT    5
`define CFG_DIR_A_SS      5

`define CFG_LAST_BIT      4'h7
`define CFG_LAST_TOGGLE   5'h0F
`define CFG_HALF_DIV4     6'h01
`define CFG_HALF_DIV16    6'h07
`define CFG_HALF_DIV64    6'h1F

`endif

// file: rtl/spi_port_pkg.sv
// types shared by the serial port design
package spi_port_pkg;

  typedef enum logic [3:0] {
    mode_master_div4   = 4'h0,
    mode_master_div16  = 4'h1,
    mode_master_div64  = 4'h2,
    mode_master_timer  = 4'h3,
    mode_slave_select  = 4'h4,
    mode_slave_free    = 4'h5,
    mode_wire_addr7    = 4'h6,
    mode_wire_addr10   = 4'h7,
    mode_wire_firmware = 4'hB,
    mode_wire_addr7_ev = 4'hE,
    mode_wire_addr10_ev = 4'hF
  } mode_type;

  typedef enum logic [1:0] {
    gen_idle = 2'b01,
    gen_run  = 2'b10
  } gen_state_type;

endpackage : spi_port_pkg

// file: rtl/sync_serial_port_spi.sv
// serial port in its SPI role with register port and interrupt
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "spi_port_cfg.svh"

// Behaviour
// - enable hands pins to port, else released
// - clock idles at polarity bit level
// - two-wire mode: polarity zero holds clock low
// - eight bits shifted both ways per transfer
// - master drives clock, slave takes it in
// - edge select picks data change edge
// - rate only master, select only slave
// - select high resets slave logic in select mode only
module sync_serial_port_spi (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       timer_two_match,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe,
  input  wire logic       slave_select_n,
  output logic            irq
);

  logic                        rst_meta;
  logic                        rst_n;
  logic                        sck_s;
  logic                        sdi_s;
  logic                        ss_n_s;
  logic [7:0]                  int_ctrl;
  logic                        port_ena;
  logic [5:0]                  dir_a;
  logic [7:0]                  dir_c;
  logic                        write_collision_flag;
  logic                        ovf;
  logic                        en;
  logic                        clock_idle_polarity;
  logic [3:0]                  mode;
  logic                        input_sample_phase;
  logic                        cke;
  logic                        bf;
  logic                        flag;
  logic [7:0]                  buffer;
  logic [7:0]                  tx;
  logic [7:0]                  rx;
  logic [3:0]                  cnt;
  spi_port_pkg::gen_state_type gen_state;
  logic [5:0]                  half_cnt;
  logic [4:0]                  toggles;
  logic                        active;
  logic                        sck_prev;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  sync_stage #(
    .WIDTH (3),
    .INIT  (3'h4)
  ) u_pin_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     ({slave_select_n, serial_in, sck_in}),
    .q     ({ss_n_s, sdi_s, sck_s})
  );

  logic is_master;
  logic is_slave;
  logic ss_ctrl;
  logic is_two_wire;
  logic spi_on;
  logic ss_hold;
  logic wr_buf;
  logic rd_buf;
  logic wr_ctrl;
  logic wr_flags;
  logic busy;

  assign is_master   = (mode[3:2] == 2'b00);
  assign ss_ctrl     = (mode == spi_port_pkg::mode_slave_select);
  assign is_slave    = ss_ctrl || (mode == spi_port_pkg::mode_slave_free);
  assign is_two_wire = (mode == spi_port_pkg::mode_wire_addr7) ||
                       (mode == spi_port_pkg::mode_wire_addr10) ||
                       (mode == spi_port_pkg::mode_wire_firmware) ||
                       (mode == spi_port_pkg::mode_wire_addr7_ev) ||
                       (mode == spi_port_pkg::mode_wire_addr10_ev);
  assign spi_on      = en && (is_master || is_slave);
  assign ss_hold     = spi_on && ss_ctrl && ss_n_s;
  assign wr_buf      = wr && (addr == `CFG_ADDR_BUFFER);
  assign rd_buf      = rd && (addr == `CFG_ADDR_BUFFER);
  assign wr_ctrl     = wr && (addr == `CFG_ADDR_CONTROL);
  assign wr_flags    = wr && (addr == `CFG_ADDR_FLAGS);
  assign busy        = is_master ? (gen_state == spi_port_pkg::gen_run) : (cnt != 4'h0);

  // master clock generator
  spi_port_pkg::gen_state_type next_gen_state;
  logic [5:0]                  next_half_cnt;
  logic [4:0]                  next_toggles;
  logic                        next_active;
  logic                        lead_m;
  logic                        trail_m;
  logic [5:0]                  half_limit;
  logic                        step;

  always_comb begin
    case (mode)
      spi_port_pkg::mode_master_div4:  half_limit = `CFG_HALF_DIV4;
      spi_port_pkg::mode_master_div16: half_limit = `CFG_HALF_DIV16;
      default:                         half_limit = `CFG_HALF_DIV64;
    endcase
    step = (mode == spi_port_pkg::mode_master_timer) ? timer_two_match :
           (half_cnt == half_limit);
    next_gen_state = gen_state;
    next_half_cnt  = half_cnt;
    next_toggles   = toggles;
    next_active    = active;
    lead_m         = 1'b0;
    trail_m        = 1'b0;
    case (gen_state)
      spi_port_pkg::gen_idle: begin
        next_active = 1'b0;
        if (spi_on && is_master && wr_buf) begin
          next_gen_state = spi_port_pkg::gen_run;
          next_half_cnt  = 6'h00;
          next_toggles   = 5'h00;
        end
      end
      spi_port_pkg::gen_run: begin
        if (step) begin
          next_half_cnt = 6'h00;
          next_active   = !active;
          lead_m        = !active;
          trail_m       = active;
          next_toggles  = toggles + 5'h01;
          if (toggles == `CFG_LAST_TOGGLE) begin
            next_gen_state = spi_port_pkg::gen_idle;
          end
        end else begin
          next_half_cnt = half_cnt + 6'h01;
        end
      end
      default: begin
        next_gen_state = spi_port_pkg::gen_idle;
      end
    endcase
    if (!spi_on || !is_master) begin
      next_gen_state = spi_port_pkg::gen_idle;
      next_active    = 1'b0;
    end
  end

  // shift engine, fed by generator or by the partner's clock
  logic       lead;
  logic       trail;
  logic       sample;
  logic       change;
  logic       done;
  logic       collision_set;
  logic [7:0] next_tx;
  logic [7:0] next_rx;
  logic [3:0] next_cnt;

  always_comb begin
    if (is_master) begin
      lead  = lead_m;
      trail = trail_m;
    end else begin
      lead  = is_slave && (sck_s ^ clock_idle_polarity) &&
              !(sck_prev ^ clock_idle_polarity);
      trail = is_slave && !(sck_s ^ clock_idle_polarity) &&
              (sck_prev ^ clock_idle_polarity);
    end
    lead     = lead && spi_on && !ss_hold;
    trail    = trail && spi_on && !ss_hold;
    sample   = cke ? lead : trail;
    change   = cke ? trail : lead;
    next_tx  = tx;
    next_rx  = rx;
    next_cnt = cnt;
    done     = 1'b0;
    collision_set = 1'b0;
    if (wr_buf && spi_on) begin
      if (busy) begin
        collision_set = 1'b1;
      end else begin
        next_tx  = wdata;
        next_cnt = 4'h0;
      end
    end else begin
      // first bit is already on the line before the first change edge
      if (change && !(!cke && cnt == 4'h0)) begin
        next_tx = {tx[6:0], 1'b0};
      end
      if (sample) begin
        next_rx = {rx[6:0], sdi_s};
        if (cnt == `CFG_LAST_BIT) begin
          next_cnt = 4'h0;
          done     = 1'b1;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
    end
    if (!spi_on || ss_hold) begin
      next_cnt = 4'h0;
    end
  end

  // registers, status and pins
  logic [7:0] next_int_ctrl;
  logic       next_port_ena;
  logic [5:0] next_dir_a;
  logic [7:0] next_dir_c;
  logic       next_write_collision_flag;
  logic       next_ovf;
  logic       next_en;
  logic       next_clock_idle_polarity;
  logic [3:0] next_mode;
  logic       next_input_sample_phase;
  logic       next_cke;
  logic       next_bf;
  logic       next_flag;
  logic [7:0] next_buffer;
  logic [7:0] next_rdata;
  logic       next_sck_out;
  logic       next_sck_oe;
  logic       next_serial_out_oe;
  logic       next_irq;
  logic       ovf_set;

  always_comb begin
    next_int_ctrl = int_ctrl;
    next_port_ena = port_ena;
    next_dir_a    = dir_a;
    next_dir_c    = dir_c;
    next_en       = en;
    next_clock_idle_polarity = clock_idle_polarity;
    next_mode     = mode;
    next_input_sample_phase = input_sample_phase;
    next_cke      = cke;
    if (wr && addr == `CFG_ADDR_INT_CTRL) next_int_ctrl = wdata;
    if (wr && addr == `CFG_ADDR_ENABLES) next_port_ena = wdata[`CFG_ENA_PORT];
    if (wr && addr == `CFG_ADDR_DIR_A) next_dir_a = wdata[5:0];
    if (wr && addr == `CFG_ADDR_DIR_C) next_dir_c = wdata;
    if (wr_ctrl) begin
      next_en   = wdata[`CFG_CTRL_EN];
      next_clock_idle_polarity = wdata[`CFG_CTRL_POL];
      next_mode = wdata[3:0];
    end
    if (wr && addr == `CFG_ADDR_STATUS) begin
      next_input_sample_phase = wdata[`CFG_STAT_PHASE];
      next_cke = wdata[`CFG_STAT_CKE];
    end
    // hardware set wins over a software clear in the same cycle
    ovf_set     = done && is_slave && bf;
    next_write_collision_flag = collision_set ||
                                (wr_ctrl ? wdata[`CFG_CTRL_COLL] : write_collision_flag);
    next_ovf    = ovf_set || (wr_ctrl ? wdata[`CFG_CTRL_OVF] : ovf);
    next_buffer = (done && !ovf_set) ? next_rx : buffer;
    next_bf     = (done && !ovf_set) || (bf && !rd_buf);
    next_flag   = done || (flag && !(wr_flags && wdata[`CFG_FLAG_PORT]));
    next_irq    = flag && port_ena;
    next_rdata  = 8'h00;
    if (rd) begin
      case (addr)
        `CFG_ADDR_INT_CTRL: next_rdata = int_ctrl;
        `CFG_ADDR_FLAGS:    next_rdata = {4'h0, flag, 3'h0};
        `CFG_ADDR_BUFFER:   next_rdata = buffer;
        `CFG_ADDR_CONTROL:  next_rdata = {write_collision_flag, ovf, en,
                                          clock_idle_polarity, mode};
        `CFG_ADDR_DIR_A:    next_rdata = {2'h0, dir_a};
        `CFG_ADDR_DIR_C:    next_rdata = dir_c;
        `CFG_ADDR_ENABLES:  next_rdata = {4'h0, port_ena, 3'h0};
        `CFG_ADDR_STATUS:   next_rdata = {input_sample_phase, cke, 5'h00, bf};
        default:            next_rdata = 8'h00;
      endcase
    end
    next_sck_oe = en && ((is_master && !dir_c[`CFG_DIR_C_SCK]) ||
                         (is_two_wire && !clock_idle_polarity));
    next_sck_out = is_two_wire ? 1'b0 : (clock_idle_polarity ^ next_active);
    next_serial_out_oe = spi_on && !dir_c[`CFG_DIR_C_DOUT] &&
                         !(ss_ctrl && ss_n_s);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_ctrl      <= `CFG_RST_INT_CTRL;
      port_ena      <= 1'b0;
      dir_a         <= `CFG_RST_DIR_A;
      dir_c         <= `CFG_RST_DIR_C;
      write_collision_flag <= 1'b0;
      ovf           <= 1'b0;
      en            <= 1'b0;
      clock_idle_polarity  <= 1'b0;
      mode          <= 4'h0;
      input_sample_phase   <= 1'b0;
      cke           <= 1'b0;
      bf            <= 1'b0;
      flag          <= 1'b0;
      buffer        <= `CFG_RST_BUFFER;
      tx            <= 8'h00;
      rx            <= 8'h00;
      cnt           <= 4'h0;
      gen_state     <= spi_port_pkg::gen_idle;
      half_cnt      <= 6'h00;
      toggles       <= 5'h00;
      active        <= 1'b0;
      sck_prev      <= 1'b0;
      rdata         <= 8'h00;
      sck_out       <= 1'b0;
      sck_oe        <= 1'b0;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
      irq           <= 1'b0;
    end else begin
      int_ctrl      <= next_int_ctrl;
      port_ena      <= next_port_ena;
      dir_a         <= next_dir_a;
      dir_c         <= next_dir_c;
      write_collision_flag <= next_write_collision_flag;
      ovf           <= next_ovf;
      en            <= next_en;
      clock_idle_polarity  <= next_clock_idle_polarity;
      mode          <= next_mode;
      input_sample_phase   <= next_input_sample_phase;
      cke           <= next_cke;
      bf            <= next_bf;
      flag          <= next_flag;
      buffer        <= next_buffer;
      tx            <= next_tx;
      rx            <= next_rx;
      cnt           <= next_cnt;
      gen_state     <= next_gen_state;
      half_cnt      <= next_half_cnt;
      toggles       <= next_toggles;
      active        <= next_active;
      sck_prev      <= sck_s;
      rdata         <= next_rdata;
      sck_out       <= next_sck_out;
      sck_oe        <= next_sck_oe;
      serial_out    <= next_tx[7];
      serial_out_oe <= next_serial_out_oe;
      irq           <= next_irq;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_pins_off;
    !en |=> !serial_out_oe && !sck_oe;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins driven while disabled");

  property p_idle_level;
    (gen_state == spi_port_pkg::gen_idle) && is_master && !wr_buf |=>
      sck_out == $past(clock_idle_polarity);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

  property p_clock_hold;
    en && is_two_wire && !clock_idle_polarity |=> sck_oe && !sck_out;
  endproperty
  a_clock_hold: assert property (p_clock_hold) else $error("clock not held low");

  property p_master_len;
    (gen_state == spi_port_pkg::gen_idle) && spi_on && mode == 4'h0 && wr_buf
      |=> (gen_state == spi_port_pkg::gen_run) ##31 (gen_state == spi_port_pkg::gen_run)
          ##1 (gen_state == spi_port_pkg::gen_idle || !spi_on);
  endproperty
  a_master_len: assert property (p_master_len) else $error("master byte length wrong");

  property p_slave_clk_in;
    en && is_slave |=> !sck_oe;
  endproperty
  a_slave_clk_in: assert property (p_slave_clk_in) else $error("slave drives clock");

  property p_change_edge;
    $changed(tx) && !$past(wr_buf) |-> $past(change);
  endproperty
  a_change_edge: assert property (p_change_edge) else $error("data moved off edge");

  property p_no_gen_slave;
    is_slave |=> gen_state == spi_port_pkg::gen_idle;
  endproperty
  a_no_gen_slave: assert property (p_no_gen_slave) else $error("generator runs in slave");

  property p_select_reset;
    spi_on && ss_ctrl && ss_n_s |=> cnt == 4'h0;
  endproperty
  a_select_reset: assert property (p_select_reset) else $error("select did not reset");

  property p_timer_toggle;
    spi_on && mode == 4'h3 && gen_state == spi_port_pkg::gen_run && timer_two_match
      |=> active != $past(active);
  endproperty
  a_timer_toggle: assert property (p_timer_toggle) else $error("timer step missed");

  property p_done_flag;
    done && !is_slave |=> flag && bf && buffer == {$past(rx[6:0]), $past(sdi_s)};
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("byte not delivered");

  c_master_done: cover property (done && is_master);
  c_slave_done:  cover property (done && is_slave);
  c_overflow:    cover property (ovf_set);
  c_collision:   cover property (collision_set);

endmodule : sync_serial_port_spi

// file: rtl/sync_stage.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module sync_stage #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : sync_stage
